//--- rtl/srlp_serial_port.sv
`timescale 1ns/100ps
// What this block does
// - Data arrives MSB first and is sampled on serial clock rising edges.
// - Eight clocks load configuration, sixteen reference, twenty-four divide word.
// - Words change only at the enable rising edge, never while shifting.
// - Low thirteen reference bits double-buffered; sixteen-bit frame fills first buffer.
// - Upper three reference bits take effect at once after sixteen-bit frame.
// - Twenty-four-bit frame copies first reference buffer into the second.
// - Enable low pulse without clocks also copies first buffer into second.
// - Frames for any word come in any order, with no address bits.
// - In data-out mode bits leave on serial clock falling edges.
// - Static 24 and a half stage shifter; serial clock may stop.
// - Enable high ignores serial clock and holds the port initialized.
// - Enable rising edge moves shifted data to the word chosen by length.
// - Port resynchronizes whenever enable is high and clock is low.
// - Output A defaults to serial data out after power-up.
module srlp_serial_port
   import srlp_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    srst,
   input  wire logic                    serial_clock,
   input  wire logic                    serial_data_in,
   input  wire logic                    latch_enable_n,
   output logic [SRLP_CFG_W-1:0]        configuration_word,
   output logic [SRLP_REF_HI-1:0]       reference_mode,
   output logic [SRLP_REF_LO-1:0]       reference_first,
   output logic [SRLP_REF_LO-1:0]       reference_counter,
   output logic [SRLP_SHIFT_W-1:0]      loop_divide_word,
   output logic                         output_a,
   output logic                         output_b_out,
   output logic                         output_b_oe
);

   // ---------------- Serial clock domain ----------------
   logic [SRLP_SHIFT_W-1:0] shift_reg;
   logic [SRLP_SHIFT_W-1:0] shift_next;
   logic [SRLP_CNT_W-1:0]   count_reg;
   logic [SRLP_CNT_W-1:0]   count_next;
   logic                    frame_tog_reg;
   logic                    frame_tog_next;
   logic                    in_frame_reg;
   logic                    half_reg;

   // Shifting only while enable is low; the first edge of a frame restarts the count
   always_comb begin
      shift_next     = shift_reg;
      count_next     = count_reg;
      frame_tog_next = frame_tog_reg;
      if (!latch_enable_n) begin
         shift_next = {shift_reg[SRLP_SHIFT_W-2:0], serial_data_in};
         if (!in_frame_reg) begin
            count_next     = SRLP_CNT_ONE;
            frame_tog_next = ~frame_tog_reg;
         end else if (count_reg != SRLP_CNT_SAT) begin
            count_next = count_reg + SRLP_CNT_ONE;
         end
      end
   end

   // No reset here: the shifter is static and any clock rate down to dc is fine
   always_ff @(posedge serial_clock) begin
      shift_reg <= shift_next;
      count_reg <= count_next;
   end

   // The frame toggle must start equal to the system side's copy, or the first
   // frames after reset would be taken for clockless pulses. The serial clock may
   // be stopped during reset, so the system reset clears it asynchronously; the
   // host keeps the serial clock low then, so the release meets no clock edge.
   always_ff @(posedge serial_clock or posedge srst) begin
      if (srst) begin
         frame_tog_reg <= 1'b0;
      end else begin
         frame_tog_reg <= frame_tog_next;
      end
   end

   // Enable high clears the frame marker, so the next frame starts clean
   always_ff @(posedge serial_clock or posedge latch_enable_n) begin
      if (latch_enable_n) begin
         in_frame_reg <= 1'b0;
      end else begin
         in_frame_reg <= 1'b1;
      end
   end

   // Half stage: MSB moves out on the falling edge for cascading
   always_ff @(negedge serial_clock) begin
      half_reg <= shift_reg[SRLP_SHIFT_W-1];
   end

   // ---------------- System clock domain ----------------
   logic enb_s1_reg;
   logic enb_s2_reg;
   logic enb_s3_reg;
   logic tog_s1_reg;
   logic tog_s2_reg;
   logic tog_seen_reg;
   logic tog_seen_next;

   logic [SRLP_CFG_W-1:0]   cfg_reg;
   logic [SRLP_CFG_W-1:0]   cfg_next;
   logic [SRLP_REF_HI-1:0]  rhi_reg;
   logic [SRLP_REF_HI-1:0]  rhi_next;
   logic [SRLP_REF_LO-1:0]  rfirst_reg;
   logic [SRLP_REF_LO-1:0]  rfirst_next;
   logic [SRLP_REF_LO-1:0]  ractive_reg;
   logic [SRLP_REF_LO-1:0]  ractive_next;
   logic [SRLP_SHIFT_W-1:0] div_reg;
   logic [SRLP_SHIFT_W-1:0] div_next;

   logic enb_rise;
   logic had_clocks;

   // Two flip-flops on the enable and the frame toggle from the serial side; the third enable stage
   // only feeds the edge detector, so nothing else reads a first stage
   always_ff @(posedge clock) begin
      enb_s1_reg <= latch_enable_n;
      enb_s2_reg <= enb_s1_reg;
      enb_s3_reg <= enb_s2_reg;
      tog_s1_reg <= frame_tog_reg;
      tog_s2_reg <= tog_s1_reg;
   end

   assign enb_rise   = enb_s2_reg & ~enb_s3_reg;
   assign had_clocks = tog_s2_reg != tog_seen_reg;

   // Shift data and count are stable while enable is high, so they are read
   // directly at the synchronised rising edge without a word handshake
   always_comb begin
      cfg_next      = cfg_reg;
      rhi_next      = rhi_reg;
      rfirst_next   = rfirst_reg;
      ractive_next  = ractive_reg;
      div_next      = div_reg;
      tog_seen_next = tog_seen_reg;
      if (enb_rise) begin
         tog_seen_next = tog_s2_reg;
         if (!had_clocks) begin
            ractive_next = rfirst_reg;
         end else if (count_reg == SRLP_CNT_CFG) begin
            cfg_next = shift_reg[SRLP_CFG_W-1:0];
         end else if (count_reg == SRLP_CNT_REF) begin
            rfirst_next = shift_reg[SRLP_REF_LO-1:0];
            rhi_next    = shift_reg[SRLP_REF_W-1:SRLP_REF_LO];
         end else if (count_reg == SRLP_CNT_DIV || count_reg > SRLP_CNT_MAXA) begin
            div_next     = shift_reg;
            ractive_next = rfirst_reg;
         end
         // Any other length up to 32 leaves every word alone
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         cfg_reg      <= SRLP_CFG_RST;
         rhi_reg      <= SRLP_RHI_RST;
         rfirst_reg   <= SRLP_RLO_RST;
         ractive_reg  <= SRLP_RLO_RST;
         div_reg      <= SRLP_DIV_RST;
         tog_seen_reg <= 1'b0;
      end else begin
         cfg_reg      <= cfg_next;
         rhi_reg      <= rhi_next;
         rfirst_reg   <= rfirst_next;
         ractive_reg  <= ractive_next;
         div_reg      <= div_next;
         tog_seen_reg <= tog_seen_next;
      end
   end

   // The toggle and its seen copy both clear on reset, so the first frame after
   // reset is told apart from a clockless enable pulse. Limitation: a reset that
   // lands in the middle of a frame loses that frame.

   assign configuration_word = cfg_reg;
   assign reference_mode     = rhi_reg;
   assign reference_first    = rfirst_reg;
   assign reference_counter  = ractive_reg;
   assign loop_divide_word   = div_reg;

   // Output A mux; the divider monitors live outside this block and read low
   always_comb begin
      unique case (srlp_oa_t'(div_reg[SRLP_DIV_MODE_H:SRLP_DIV_MODE_L]))
         SRLP_OA_PORT: output_a = cfg_reg[SRLP_CFG_PORT];
         SRLP_OA_DOUT: output_a = half_reg;
         SRLP_OA_FV:   output_a = 1'b0;
         SRLP_OA_FR:   output_a = 1'b0;
      endcase
   end

   // Open drain: released when the bit is high, pulled low otherwise
   assign output_b_out = 1'b0;
   assign output_b_oe  = ~cfg_reg[SRLP_CFG_OUTB];

   // ---------------- Checks ----------------
   logic len_bad;
   assign len_bad = had_clocks && count_reg != SRLP_CNT_CFG && count_reg != SRLP_CNT_REF
                    && count_reg != SRLP_CNT_DIV && count_reg <= SRLP_CNT_MAXA;

   cfg_load_a: assert property (@(posedge clock) disable iff (srst)
      enb_rise && had_clocks && count_reg == SRLP_CNT_CFG
      |=> configuration_word == $past(shift_reg[SRLP_CFG_W-1:0]))
      else $error("configuration word not loaded by 8-clock frame");

   ref_first_a: assert property (@(posedge clock) disable iff (srst)
      enb_rise && had_clocks && count_reg == SRLP_CNT_REF
      |=> reference_first == $past(shift_reg[SRLP_REF_LO-1:0]) && $stable(reference_counter))
      else $error("16-clock frame did not fill only the first buffer");

   ref_upper_a: assert property (@(posedge clock) disable iff (srst)
      enb_rise && had_clocks && count_reg == SRLP_CNT_REF
      |=> reference_mode == $past(shift_reg[SRLP_REF_W-1:SRLP_REF_LO]))
      else $error("upper reference bits not applied at once");

   div_swap_a: assert property (@(posedge clock) disable iff (srst)
      enb_rise && had_clocks && count_reg == SRLP_CNT_DIV
      |=> loop_divide_word == $past(shift_reg) && reference_counter == $past(reference_first))
      else $error("24-clock frame did not load divide word and second buffer");

   zero_clk_a: assert property (@(posedge clock) disable iff (srst)
      enb_rise && !had_clocks
      |=> reference_counter == $past(reference_first) && $stable(loop_divide_word))
      else $error("clockless enable pulse did not copy the first buffer");

   bad_len_a: assert property (@(posedge clock) disable iff (srst)
      enb_rise && len_bad
      |=> $stable(configuration_word) && $stable(loop_divide_word)
          && $stable(reference_first) && $stable(reference_mode))
      else $error("illegal frame length changed a word");

   quiet_hold_a: assert property (@(posedge clock) disable iff (srst)
      !enb_rise |=> $stable(configuration_word) && $stable(loop_divide_word)
                    && $stable(reference_counter))
      else $error("word changed without an enable rising edge");

   rise_delay_a: assert property (@(posedge clock) disable iff (srst)
      enb_rise |=> !enb_rise)
      else $error("one enable rising edge loaded twice");

   outb_a: assert property (@(posedge clock) disable iff (srst)
      output_b_oe == !configuration_word[SRLP_CFG_OUTB] && output_b_out == 1'b0)
      else $error("output B does not follow its configuration bit");

   dout_sel_a: assert property (@(posedge clock) disable iff (srst)
      loop_divide_word[SRLP_DIV_MODE_H:SRLP_DIV_MODE_L] == SRLP_OA_DOUT |-> output_a == half_reg)
      else $error("output A not carrying serial data out");

   // A 16-clock frame touches only the reference words
   ref_keep_a: assert property (@(posedge clock) disable iff (srst)
      enb_rise && had_clocks && count_reg == SRLP_CNT_REF
      |=> $stable(loop_divide_word) && $stable(configuration_word))
      else $error("16-clock frame changed another word");

   // An 8-clock frame touches only the configuration word
   cfg_keep_a: assert property (@(posedge clock) disable iff (srst)
      enb_rise && had_clocks && count_reg == SRLP_CNT_CFG
      |=> $stable(loop_divide_word) && $stable(reference_first)
          && $stable(reference_counter) && $stable(reference_mode))
      else $error("8-clock frame changed another word");

   // The reference halves also hold between enable rising edges
   quiet_ref_a: assert property (@(posedge clock) disable iff (srst)
      !enb_rise |=> $stable(reference_first) && $stable(reference_mode))
      else $error("reference word changed without an enable rising edge");

   // Reset leaves output A in data-out mode so a cascade works unprogrammed
   reset_dout_a: assert property (@(posedge clock)
      $fell(srst) |-> loop_divide_word[SRLP_DIV_MODE_H:SRLP_DIV_MODE_L] == SRLP_OA_DOUT)
      else $error("output A not in data-out mode after reset");

   // ---------------- Serial side checks ----------------
   // These run on the serial clock; the shifter has no reset, so most look only
   // at the bit just taken and at the counter; only shift_idle_a reads the whole shifter.
   shift_in_a: assert property (@(posedge serial_clock)
      !latch_enable_n |=> shift_reg[0] == $past(serial_data_in))
      else $error("serial bit not taken on the rising clock edge");

   // Clocks with enable high must leave the port as it is
   shift_idle_a: assert property (@(posedge serial_clock)
      latch_enable_n |=> $stable(shift_reg) && $stable(count_reg))
      else $error("serial clock moved the port while enable was high");

   // The first clock of a frame restarts the count
   count_first_a: assert property (@(posedge serial_clock)
      !latch_enable_n && !in_frame_reg |=> count_reg == SRLP_CNT_ONE)
      else $error("first clock of a frame did not restart the count");

   // Later clocks add one until the count saturates
   count_step_a: assert property (@(posedge serial_clock)
      !latch_enable_n && in_frame_reg && count_reg != SRLP_CNT_SAT
      |=> count_reg == $past(count_reg) + SRLP_CNT_ONE)
      else $error("frame clock not counted");

endmodule

//--- rtl/srlp_pkg.sv
package srlp_pkg;

   // Serial frame geometry
   localparam int unsigned SRLP_SHIFT_W = 24;
   localparam int unsigned SRLP_CNT_W   = 6;
   localparam int unsigned SRLP_CFG_W   = 8;
   localparam int unsigned SRLP_REF_W   = 16;
   localparam int unsigned SRLP_REF_LO  = 13;
   localparam int unsigned SRLP_REF_HI  = 3;

   // Clock counts that pick the destination word, then the count's start and saturation values
   localparam logic [SRLP_CNT_W-1:0] SRLP_CNT_CFG  = 6'h08;
   localparam logic [SRLP_CNT_W-1:0] SRLP_CNT_REF  = 6'h10;
   localparam logic [SRLP_CNT_W-1:0] SRLP_CNT_DIV  = 6'h18;
   localparam logic [SRLP_CNT_W-1:0] SRLP_CNT_MAXA = 6'h20;
   localparam logic [SRLP_CNT_W-1:0] SRLP_CNT_SAT  = 6'h3f;
   localparam logic [SRLP_CNT_W-1:0] SRLP_CNT_ONE  = 6'h01;

   // Field positions
   localparam int unsigned SRLP_CFG_OUTB   = 0;
   localparam int unsigned SRLP_CFG_PORT   = 1;
   localparam int unsigned SRLP_DIV_MODE_H = 23;
   localparam int unsigned SRLP_DIV_MODE_L = 22;

   // Reset values; loop word resets with output A set to serial data out
   localparam logic [SRLP_CFG_W-1:0]   SRLP_CFG_RST = 8'h00;
   localparam logic [SRLP_REF_HI-1:0]  SRLP_RHI_RST = 3'h1;
   localparam logic [SRLP_REF_LO-1:0]  SRLP_RLO_RST = 13'h0000;
   localparam logic [SRLP_SHIFT_W-1:0] SRLP_DIV_RST = 24'h400000;

   // Output A selections from the two top bits of the loop word
   typedef enum logic [1:0] {
      SRLP_OA_PORT = 2'h0,
      SRLP_OA_DOUT = 2'h1,
      SRLP_OA_FV   = 2'h2,
      SRLP_OA_FR   = 2'h3
   } srlp_oa_t;

endpackage

//--- test/srlp_host_model.sv
`timescale 1ns/100ps
// Host side of the serial link: frames the enable and makes the shift clock
module srlp_host_model (
   output logic      serial_clock,
   output logic      serial_data_in,
   output logic      latch_enable_n,
   input  wire logic output_a
);
   // Clock low from time zero; enable rises just after it, so the frame marker
   // sees a real rising edge, and then stays high to keep the port initialized
   initial begin
      serial_clock   = 1'b0;
      serial_data_in = 1'b0;
      latch_enable_n = 1'b0;
      #1 latch_enable_n = 1'b1;
   end

   // Clock bursts with enable high; the port must ignore them
   task automatic idle_clocks(input int n);
      repeat (n) begin
         #6 serial_clock = 1'b1;
         #6 serial_clock = 1'b0;
      end
   endtask

   // One frame, MSB first; zero clocks gives a bare enable pulse.
   // Output A is taken just before each rising edge, as a cascaded part takes it.
   task automatic frame(input int n, input logic [31:0] data, output logic [31:0] cap);
      cap = 32'h0;
      latch_enable_n = 1'b0;
      #100;
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_in = data[i];
         cap            = {cap[30:0], output_a};
         #5 serial_clock = 1'b1;
         #6 serial_clock = 1'b0;
         #1;
      end
      // Inverted after the last clock, before enable rises, so a stale bit cannot pass for a fresh one
      serial_data_in = ~serial_data_in;
      #100 latch_enable_n = 1'b1;
      #400;
   endtask
endmodule

//--- test/srlp_serial_port_tb_top.sv
`timescale 1ns/100ps
`define SRLP_CHK(got, exp) begin \
   total_checks++; \
   if ((got) !== (exp)) begin \
      failures++; \
      $display("ERROR t=%0t got %h exp %h", $time, got, exp); \
   end \
end
module srlp_serial_port_tb_top;
   logic        clock;
   logic        srst;
   logic        serial_clock;
   logic        serial_data_in;
   logic        latch_enable_n;
   logic [7:0]  configuration_word;
   logic [2:0]  reference_mode;
   logic [12:0] reference_first;
   logic [12:0] reference_counter;
   logic [23:0] loop_divide_word;
   logic        output_a;
   logic        output_b_out;
   logic        output_b_oe;
   logic [31:0] cap;
   int          failures = 0;
   int          total_checks = 0;

   srlp_serial_port u_dut (
      .clock             (clock),
      .srst              (srst),
      .serial_clock      (serial_clock),
      .serial_data_in    (serial_data_in),
      .latch_enable_n    (latch_enable_n),
      .configuration_word(configuration_word),
      .reference_mode    (reference_mode),
      .reference_first   (reference_first),
      .reference_counter (reference_counter),
      .loop_divide_word  (loop_divide_word),
      .output_a          (output_a),
      .output_b_out      (output_b_out),
      .output_b_oe       (output_b_oe)
   );

   srlp_host_model u_host (
      .serial_clock  (serial_clock),
      .serial_data_in(serial_data_in),
      .latch_enable_n(latch_enable_n),
      .output_a      (output_a)
   );

   // System clock, 50 ns period
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // Verdict and end of run
   task automatic end_sim;
      if (failures == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Watchdog sized well above the ten frames of the run
   initial begin
      #100000;
      failures++;
      end_sim();
   end

   // Main sequence; the first frame is a full divide word so the shifter is known
   initial begin
      // Raised just after time zero so the serial side sees a reset edge
      srst = 1'b0;
      #1 srst = 1'b1;
      repeat (16) @(negedge clock);
      srst = 1'b0;
      repeat (2) @(negedge clock);
      `SRLP_CHK(configuration_word, 8'h00)
      `SRLP_CHK(reference_mode, 3'h1)
      `SRLP_CHK(reference_counter, 13'h0000)
      `SRLP_CHK(loop_divide_word, 24'h400000)
      `SRLP_CHK({output_b_oe, output_b_out}, 2'h2)
      // Divide words used here keep the main count at or above the swallow count
      u_host.frame(24, 32'h5a5a5a, cap);
      `SRLP_CHK(loop_divide_word, 24'h5a5a5a)
      `SRLP_CHK(reference_counter, 13'h0000)
      u_host.frame(16, 32'h6abc, cap);
      `SRLP_CHK(reference_mode, 3'h3)
      `SRLP_CHK(reference_first, 13'h0abc)
      `SRLP_CHK(reference_counter, 13'h0000)
      u_host.idle_clocks(5);
      u_host.frame(0, 32'h0, cap);
      `SRLP_CHK(reference_counter, 13'h0abc)
      u_host.frame(16, 32'h2123, cap);
      `SRLP_CHK(reference_first, 13'h0123)
      `SRLP_CHK(reference_counter, 13'h0abc)
      // Data out replays the shifter's previous content, MSB first
      u_host.frame(24, 32'h412345, cap);
      `SRLP_CHK(cap[23:0], 24'hbc2123)
      `SRLP_CHK(loop_divide_word, 24'h412345)
      `SRLP_CHK(reference_counter, 13'h0123)
      u_host.frame(8, 32'ha7, cap);
      `SRLP_CHK(configuration_word, 8'ha7)
      `SRLP_CHK(output_b_oe, 1'b0)
      u_host.frame(12, 32'h0f0, cap);
      `SRLP_CHK(configuration_word, 8'ha7)
      `SRLP_CHK(reference_first, 13'h0123)
      `SRLP_CHK(loop_divide_word, 24'h412345)
      u_host.frame(24, 32'h012345, cap);
      `SRLP_CHK(output_a, 1'b1)
      u_host.frame(32, 32'h89abcdef, cap);
      `SRLP_CHK(loop_divide_word, 24'h012345)
      `SRLP_CHK(configuration_word, 8'ha7)
      u_host.frame(24, 32'h812345, cap);
      `SRLP_CHK(loop_divide_word, 24'h812345)
      `SRLP_CHK(output_a, 1'b0)
      end_sim();
   end
endmodule
